// [hw/flfs_top.v]
// Free-run, integrator force/readback, spread and status control for two loops
//
// Contract
// - In free-run, stop correction, hold integrator, ignore the reference.
// - Entering free-run from lock keeps the current frequency word.
// - Lost reference makes the main loop free-run regardless of free-run bit.
// - With free-run clear, loop re-locks whenever reference returns.
// - Writing apply loads forced value into integrator, only while free-running; loads only with the free-run bit set, not on reference loss alone.
// - Forced value at bits 11:0, apply trigger at bit 15.
// - Cold start in free-run uses forced value reset default 181h or 000h.
// - Readback integrator at bits 11:0, valid flag at bit 15, read-only.
// - Free-run enable bit 1, resets 1 for loop one, 0 for two.
// - Spread select bits 1:0: off, zero-mean FM, triangle, dither; reset 00.
// - Spread amplitude bits 5:4 select modulation depth codes 00 to 11.
// - Spread rate bits 3:2 set triangle frequency; triangle mode only.
// - Each loop keeps its own spread type, amplitude and rate.
// - Clock-good asserts once the loop started and delivers output.
// - Lock status shows whether frequency lock was achieved.
// - Statuses debounced toward interrupt logic, needing a debounce clock.
// - GPIO statuses bypass debouncing.
// - Sync bandwidth bit 0: 0 wide, 1 narrow; reset 1.
// - Oscillator runs at output times divider; output is oscillator divided.
// - Loop output selectable as main system or secondary async clock source.
// - Loop enable is bit 0, reset 0, set last.
`timescale 1ns/10ps
`include "flfs_regs.vh"

module flfs_top (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  // Register port
  input  wire [11:0] i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  // Loop one analogue side
  input  wire        i_l1_ref_present,
  input  wire [11:0] i_l1_correction,
  input  wire        i_l1_osc_running,
  output reg  [11:0] o_l1_integ,
  output reg         o_l1_run,
  output reg         o_l1_feedback_en,
  output reg  [5:0]  o_l1_spread,
  output reg         o_l1_sync_narrow,
  // Loop two analogue side
  input  wire        i_l2_ref_present,
  input  wire [11:0] i_l2_correction,
  input  wire        i_l2_osc_running,
  output reg  [11:0] o_l2_integ,
  output reg         o_l2_run,
  output reg         o_l2_feedback_en,
  output reg  [5:0]  o_l2_spread,
  output reg         o_l2_sync_narrow,
  // Clock source selection
  input  wire [1:0]  i_sys_src_sel,
  input  wire [1:0]  i_async_src_sel,
  output reg  [1:0]  o_main_system_clock_src,
  output reg  [1:0]  o_secondary_async_clock_src,
  // Status
  input  wire        i_slow_tick,
  input  wire        i_main_system_clock_on,
  output reg  [1:0]  o_clk_good_gpio,
  output reg  [1:0]  o_lock_gpio,
  output reg  [1:0]  o_clk_good_irq,
  output reg  [1:0]  o_lock_irq
);

  // Per-loop state, index 0 is loop one
  reg        loop_enable [0:1];
  reg        free_run_enable [0:1];
  reg [11:0] forced_integrator_value [0:1];
  reg [5:0]  spread_cfg [0:1];
  reg        sync_bandwidth_select [0:1];
  reg [11:0] integ [0:1];
  reg        integ_valid [0:1];
  reg        was_running [0:1];
  reg [7:0]  start_cnt [0:1];
  reg        clk_good [0:1];
  reg        locked [0:1];
  wire [3:0] deb_state;

  // Pin synchronisers: ref present and osc running per loop
  reg [3:0]  sync1;
  reg [3:0]  sync2;
  reg [1:0]  tick_s1;
  reg [1:0]  tick_s2;
  reg        tick_d;
  wire [1:0] ref_ok  = {sync2[1], sync2[0]};
  wire [1:0] osc_ok  = {sync2[3], sync2[2]};
  wire       deb_en  = (tick_s2[0] & ~tick_d) | tick_s2[1];

  wire [11:0] corr [0:1];
  assign corr[0] = i_l1_correction;
  assign corr[1] = i_l2_correction;

  wire [1:0] wr_ctrl  = {i_wr & (i_addr == `FLFS_L2_CTRL1), i_wr & (i_addr == `FLFS_L1_CTRL1)};
  wire [1:0] wr_force = {i_wr & (i_addr == `FLFS_L2_FORCE), i_wr & (i_addr == `FLFS_L1_FORCE)};
  wire [1:0] wr_spr   = {i_wr & (i_addr == `FLFS_L2_SPREAD), i_wr & (i_addr == `FLFS_L1_SPREAD)};
  wire [1:0] wr_sbw   = {i_wr & (i_addr == `FLFS_L2_SYNCBW), i_wr & (i_addr == `FLFS_L1_SYNCBW)};

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1   <= 4'h0;
      sync2   <= 4'h0;
      tick_s1 <= 2'h0;
      tick_s2 <= 2'h0;
      tick_d  <= 1'b0;
    end else begin
      sync1   <= {i_l2_osc_running, i_l1_osc_running, i_l2_ref_present, i_l1_ref_present};
      sync2   <= sync1;
      tick_s1 <= {i_main_system_clock_on, i_slow_tick};
      tick_s2 <= tick_s1;
      tick_d  <= tick_s2[0];
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_loop
      // Free-run in effect: requested, or this loop lost its reference
      wire fr_eff = free_run_enable[g] | ~ref_ok[g];
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          loop_enable[g]     <= 1'b0;
          free_run_enable[g] <= (g == 0) ? `FLFS_L1_FREERUN_RST : `FLFS_L2_FREERUN_RST;
          forced_integrator_value[g] <= (g == 0) ? `FLFS_L1_FORCE_RST : `FLFS_L2_FORCE_RST;
          spread_cfg[g]      <= 6'h00;
          sync_bandwidth_select[g] <= `FLFS_SYNCBW_RST;
          integ[g]       <= 12'h000;
          integ_valid[g] <= 1'b0;
          was_running[g] <= 1'b0;
          start_cnt[g]   <= 8'h00;
          clk_good[g]    <= 1'b0;
          locked[g]      <= 1'b0;
        end else begin
          if (wr_ctrl[g]) begin
            loop_enable[g]     <= i_wdata[`FLFS_BIT_ENA];
            free_run_enable[g] <= i_wdata[`FLFS_BIT_FREERUN];
          end
          if (wr_force[g])
            forced_integrator_value[g] <= i_wdata[11:0];
          if (wr_spr[g])
            spread_cfg[g] <= i_wdata[5:0];
          if (wr_sbw[g])
            sync_bandwidth_select[g] <= i_wdata[0];
          if (!loop_enable[g]) begin
            // Loop idle: nothing running, next start is a cold start
            was_running[g] <= 1'b0;
            integ_valid[g] <= 1'b0;
            start_cnt[g]   <= 8'h00;
            clk_good[g]    <= 1'b0;
            locked[g]      <= 1'b0;
          end else begin
            was_running[g] <= 1'b1;
            if (!was_running[g] && fr_eff)
              integ[g] <= forced_integrator_value[g];
            else if (wr_force[g] && i_wdata[`FLFS_BIT_APPLY] && free_run_enable[g])
              integ[g] <= i_wdata[11:0];
            else if (!fr_eff)
              integ[g] <= integ[g] + corr[g];
            // Hold otherwise keeps frequency on free-run entry
            integ_valid[g] <= free_run_enable[g] & was_running[g];
            if (osc_ok[g] && start_cnt[g] != `FLFS_START_CYCLES)
              start_cnt[g] <= start_cnt[g] + 8'h01;
            clk_good[g] <= osc_ok[g] && start_cnt[g] == `FLFS_START_CYCLES;
            locked[g] <= ~fr_eff & clk_good[g] &
                         ((corr[g] < `FLFS_LOCK_ERR_TOL) |
                          (corr[g] > (12'hfff - `FLFS_LOCK_ERR_TOL)));
          end
        end
      end

      // Debouncers: index 2g clock-good, 2g+1 lock
      flfs_debounce u_deb_good (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_step    (deb_en),
        .i_level   (clk_good[g]),
        .o_state   (deb_state[2*g])
      );
      flfs_debounce u_deb_lock (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_step    (deb_en),
        .i_level   (locked[g]),
        .o_state   (deb_state[2*g+1])
      );
    end
  endgenerate

  // Outputs to the oscillators, clock muxes and status consumers
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_l1_integ <= 12'h000;
      o_l2_integ <= 12'h000;
      o_l1_run <= 1'b0;
      o_l2_run <= 1'b0;
      o_l1_feedback_en <= 1'b0;
      o_l2_feedback_en <= 1'b0;
      o_l1_spread <= 6'h00;
      o_l2_spread <= 6'h00;
      o_l1_sync_narrow <= `FLFS_SYNCBW_RST;
      o_l2_sync_narrow <= `FLFS_SYNCBW_RST;
      o_main_system_clock_src <= 2'h0;
      o_secondary_async_clock_src <= 2'h0;
      o_clk_good_gpio <= 2'h0;
      o_lock_gpio <= 2'h0;
      o_clk_good_irq <= 2'h0;
      o_lock_irq <= 2'h0;
    end else begin
      // Integrator word sets oscillator rate; output dividers sit beyond it
      o_l1_integ <= integ[0];
      o_l2_integ <= integ[1];
      o_l1_run <= loop_enable[0];
      o_l2_run <= loop_enable[1];
      o_l1_feedback_en <= loop_enable[0] & ~free_run_enable[0] & ref_ok[0];
      o_l2_feedback_en <= loop_enable[1] & ~free_run_enable[1] & ref_ok[1];
      // Rate field forced to zero outside triangle
      o_l1_spread <= {spread_cfg[0][5:4],
                      (spread_cfg[0][1:0] == `FLFS_SS_TRI) ? spread_cfg[0][3:2] : 2'h0,
                      spread_cfg[0][1:0]};
      o_l2_spread <= {spread_cfg[1][5:4],
                      (spread_cfg[1][1:0] == `FLFS_SS_TRI) ? spread_cfg[1][3:2] : 2'h0,
                      spread_cfg[1][1:0]};
      o_l1_sync_narrow <= sync_bandwidth_select[0];
      o_l2_sync_narrow <= sync_bandwidth_select[1];
      o_main_system_clock_src <= i_sys_src_sel;
      o_secondary_async_clock_src <= i_async_src_sel;
      o_clk_good_gpio <= {clk_good[1], clk_good[0]};
      o_lock_gpio <= {locked[1], locked[0]};
      o_clk_good_irq <= {deb_state[2], deb_state[0]};
      o_lock_irq <= {deb_state[3], deb_state[1]};
    end
  end

  // Read data, one cycle after the strobe; apply bit always reads zero
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_rdata <= 16'h0000;
    else if (i_rd) begin
      case (i_addr)
        `FLFS_L1_CTRL1:    o_rdata <= {14'h0000, free_run_enable[0], loop_enable[0]};
        `FLFS_L2_CTRL1:    o_rdata <= {14'h0000, free_run_enable[1], loop_enable[1]};
        `FLFS_L1_FORCE:    o_rdata <= {4'h0, forced_integrator_value[0]};
        `FLFS_L2_FORCE:    o_rdata <= {4'h0, forced_integrator_value[1]};
        `FLFS_L1_READBACK: o_rdata <= {integ_valid[0], 3'h0, integ[0]};
        `FLFS_L2_READBACK: o_rdata <= {integ_valid[1], 3'h0, integ[1]};
        `FLFS_L1_SPREAD:   o_rdata <= {10'h000, spread_cfg[0]};
        `FLFS_L2_SPREAD:   o_rdata <= {10'h000, spread_cfg[1]};
        `FLFS_L1_SYNCBW:   o_rdata <= {15'h0000, sync_bandwidth_select[0]};
        `FLFS_L2_SYNCBW:   o_rdata <= {15'h0000, sync_bandwidth_select[1]};
        `FLFS_L1_STATUS:   o_rdata <= {14'h0000, locked[0], clk_good[0]};
        `FLFS_L2_STATUS:   o_rdata <= {14'h0000, locked[1], clk_good[1]};
        default:           o_rdata <= 16'h0000;
      endcase
    end else
      o_rdata <= 16'h0000;
  end

endmodule

// Status debouncer: level must differ for CYCLES steps before it is taken
module flfs_debounce #(
  parameter CNT_W  = 4,
  parameter CYCLES = 8
) (
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_rst_n,
  // Step enable and raw level
  input  wire i_step,
  input  wire i_level,
  // Debounced level
  output reg  o_state
);

  localparam [CNT_W-1:0] LAST = CYCLES - 1;

  reg [CNT_W-1:0] cnt;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt     <= {CNT_W{1'b0}};
      o_state <= 1'b0;
    end else if (i_step) begin
      if (i_level == o_state)
        cnt <= {CNT_W{1'b0}};
      else if (cnt == LAST) begin
        o_state <= i_level;
        cnt     <= {CNT_W{1'b0}};
      end else
        cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// [hw/flfs_regs.vh]
// Register offsets, field positions and reset values of the loop control block
`ifndef FLFS_REGS_VH
`define FLFS_REGS_VH
`define FLFS_L1_CTRL1      12'h171
`define FLFS_L1_FORCE      12'h177
`define FLFS_L1_READBACK   12'h178
`define FLFS_L1_SPREAD     12'h189
`define FLFS_L1_SYNCBW     12'h187
`define FLFS_L2_CTRL1      12'h191
`define FLFS_L2_FORCE      12'h197
`define FLFS_L2_READBACK   12'h198
`define FLFS_L2_SPREAD     12'h1a9
`define FLFS_L2_SYNCBW     12'h1a7
`define FLFS_L1_STATUS     12'h1f0
`define FLFS_L2_STATUS     12'h1f1
`define FLFS_BIT_ENA       0
`define FLFS_BIT_FREERUN   1
`define FLFS_BIT_APPLY     15
`define FLFS_BIT_VALID     15
`define FLFS_L1_FREERUN_RST 1'b1
`define FLFS_L2_FREERUN_RST 1'b0
`define FLFS_L1_FORCE_RST  12'h181
`define FLFS_L2_FORCE_RST  12'h000
`define FLFS_SYNCBW_RST    1'b1
`define FLFS_SS_OFF        2'h0
`define FLFS_SS_ZERO_MEAN_FM       2'h1
`define FLFS_SS_TRI        2'h2
`define FLFS_SS_DITHER     2'h3
`define FLFS_DEB_CYCLES    4'h8
`define FLFS_START_CYCLES  8'h40
`define FLFS_LOCK_ERR_TOL  12'h004
`endif

// [verification/flfs_top_properties.sv]
// Port-level properties of the two-loop control block
`timescale 1ns/10ps
module flfs_checker (
  // Clock, reset and register port
  input wire        i_ref_clk,
  input wire        i_rst_n,
  input wire        i_rd,
  input wire        i_wr,
  input wire [11:0] i_addr,
  input wire [15:0] o_rdata,
  // Loop outputs
  input wire        o_l1_run,
  input wire        o_l1_feedback_en,
  input wire [11:0] o_l1_integ,
  input wire [5:0]  o_l1_spread,
  input wire [5:0]  o_l2_spread,
  // Status and clock sources
  input wire [1:0]  i_sys_src_sel,
  input wire [1:0]  o_main_system_clock_src,
  input wire [1:0]  o_clk_good_gpio,
  input wire [1:0]  o_lock_gpio,
  input wire [1:0]  o_clk_good_irq
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_one_cycle: assert property (o_rdata != 16'h0000 |-> $past(i_rd))
    else $error("read data outside the answer cycle");
  a_unmapped_read: assert property (i_rd && i_addr == 12'h000 |=> o_rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_hold_free_run: assert property (!o_l1_feedback_en && $past(!o_l1_feedback_en) && !i_wr
      && !$past(i_wr) && !$past(i_wr, 2) && !$past(i_wr, 3)
      |=> o_l1_feedback_en || $stable(o_l1_integ))
    else $error("integrator moved without feedback");
  a_feedback_needs_run: assert property (o_l1_feedback_en |-> o_l1_run)
    else $error("feedback active with loop disabled");
  a_good_needs_run: assert property (o_clk_good_gpio[0] |-> o_l1_run || $past(o_l1_run))
    else $error("clock good without loop running");
  a_lock_needs_good: assert property ((o_lock_gpio & ~o_clk_good_gpio) == 2'h0)
    else $error("lock shown without clock good");
  a_irq_debounced: assert property ($rose(o_clk_good_irq[0])
      |-> o_clk_good_gpio[0] && $past(o_clk_good_gpio[0], 7))
    else $error("interrupt status rose before debounce");
  a_rate_tri_only: assert property (o_l1_spread[1:0] != 2'h2 |-> o_l1_spread[3:2] == 2'h0)
    else $error("loop one rate outside triangle");
  a_rate_tri_two: assert property (o_l2_spread[1:0] != 2'h2 |-> o_l2_spread[3:2] == 2'h0)
    else $error("loop two rate outside triangle");
  a_source_select: assert property ($past(i_rst_n)
      |-> o_main_system_clock_src == $past(i_sys_src_sel))
    else $error("system clock source not passed");
  c_free_run: cover property (o_l1_run && !o_l1_feedback_en);
  c_locked: cover property (o_lock_gpio[1]);
  c_irq: cover property ($rose(o_clk_good_irq[0]));
endmodule
bind flfs_top flfs_checker u_chk (.*);

// [verification/flfs_top_test.sv]
// Self-checking bench for the two-loop control block
`timescale 1ns/10ps
module flfs_top_test;
  logic        i_ref_clk, i_rst_n, i_wr, i_rd, i_slow_tick, i_main_system_clock_on, rd_d, rnd1, rnd2;
  logic        i_l1_ref_present, i_l1_osc_running, i_l2_ref_present, i_l2_osc_running;
  logic [11:0] i_addr, c1, c2, held, i_l1_correction = 12'h000, i_l2_correction = 12'h000;
  logic [15:0] i_wdata, v, exp_q[$];
  logic [1:0]  i_sys_src_sel = 2'h0, i_async_src_sel = 2'h0, async_d = 2'h0;
  wire  [15:0] o_rdata;
  wire  [11:0] o_l1_integ, o_l2_integ;
  wire  [5:0]  o_l1_spread, o_l2_spread;
  wire         o_l1_run, o_l1_feedback_en, o_l1_sync_narrow;
  wire         o_l2_run, o_l2_feedback_en, o_l2_sync_narrow;
  wire  [1:0]  o_main_system_clock_src, o_secondary_async_clock_src;
  wire  [1:0]  o_clk_good_gpio, o_lock_gpio, o_clk_good_irq, o_lock_irq;
  integer      seed = 62, bad_count = 0, check_count = 0, n, k;
  logic [11:0] ra[10] = '{12'h171, 12'h191, 12'h177, 12'h197, 12'h189, 12'h1a9, 12'h187,
                         12'h1a7, 12'h198, 12'h000};
  logic [15:0] rv[10] = '{16'h0002, 16'h0000, 16'h0181, 16'h0000, 16'h0000, 16'h0000,
                         16'h0001, 16'h0001, 16'h0000, 16'h0000};
  flfs_top dut (.*);
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    i_sys_src_sel <= $random(seed);
    i_async_src_sel <= $random(seed);
    i_l1_correction <= rnd1 ? 12'($random(seed)) : c1;
    i_l2_correction <= rnd2 ? 12'($random(seed)) : c2;
    rd_d <= i_rd;
    async_d <= i_async_src_sel;
  end
  // Watcher: oldest noted read result against the answer cycle
  always @(negedge i_ref_clk) begin
    if (rd_d === 1'b1) chk(o_rdata, exp_q.pop_front());
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic [15:0] d, input logic w, input logic r);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= w;
    i_rd <= r;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(a, 16'h0000, 1'b0, 1'b1);
  endtask
  task automatic cyc(input integer m);
    repeat (m) @(posedge i_ref_clk);
    #1;
  endtask
  function automatic logic [5:0] sp(input logic [15:0] d);
    sp = {d[5:4], (d[1:0] == 2'h2) ? d[3:2] : 2'h0, d[1:0]};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    bad_count++;
    complete_run;
  end
  initial begin
    {i_wr, i_rd, i_slow_tick, i_main_system_clock_on, rnd1, rnd2, rd_d, i_rst_n} = 8'h00;
    {i_l1_ref_present, i_l1_osc_running, i_l2_ref_present, i_l2_osc_running} = 4'hf;
    i_addr = 12'h000;
    i_wdata = 16'h0000;
    c1 = 12'h000;
    c2 = 12'h000;
    cyc(3);
    i_rst_n <= 1'b1;
    cyc(1);
    foreach (ra[j]) rd(ra[j], rv[j]);
    chk({15'h0, o_l1_sync_narrow}, 16'h0001);
    bus(12'h1a7, 16'h0000, 1'b1, 1'b0);
    chk({15'h0, o_l2_sync_narrow}, 16'h0000);
    $display("reset values done");
    for (k = 0; k < 4; k++) begin
      v = ($random(seed) & 16'h003c) | 16'(k);
      bus(12'h189, v, 1'b1, 1'b0);
      bus(12'h1a9, {v[15:2], 2'(3 - k)}, 1'b1, 1'b0);
      chk({10'h0, o_l1_spread}, {10'h0, sp(v)});
      chk({10'h0, o_l2_spread}, {10'h0, sp({v[15:2], 2'(3 - k)})});
      rd(12'h189, v);
      chk({14'h0, o_secondary_async_clock_src}, {14'h0, async_d});
    end
    $display("spread done");
    // Ratio and predivider settings stay at defaults outside this block
    bus(12'h171, 16'h0003, 1'b1, 1'b0);
    cyc(3);
    chk({o_l1_run, o_l1_feedback_en, o_l1_integ}, {2'h2, 12'h181});
    rnd1 = 1'b1;
    cyc(10);
    chk({4'h0, o_l1_integ}, 16'h0181);
    rnd1 = 1'b0;
    v = $random(seed) & 16'h0fff;
    bus(12'h177, v | 16'h8000, 1'b1, 1'b0);
    cyc(1);
    chk({4'h0, o_l1_integ}, v);
    rd(12'h177, v);
    rd(12'h178, v | 16'h8000);
    for (n = 0; n < 300 && o_clk_good_gpio[0] !== 1'b1; n++) @(posedge i_ref_clk);
    chk({o_clk_good_gpio[0], o_clk_good_irq[0], o_lock_gpio[0]}, 16'h0004);
    $display("free run done");
    bus(12'h171, 16'h0001, 1'b1, 1'b0);
    cyc(5);
    chk({15'h0, o_l1_feedback_en}, 16'h0001);
    i_l1_ref_present <= 1'b0;
    cyc(5);
    chk({15'h0, o_l1_feedback_en}, 16'h0000);
    held = o_l1_integ;
    rnd1 = 1'b1;
    cyc(8);
    chk({4'h0, o_l1_integ}, {4'h0, held});
    rnd1 = 1'b0;
    i_l1_ref_present <= 1'b1;
    cyc(5);
    chk({15'h0, o_l1_feedback_en}, 16'h0001);
    $display("reference loss done");
    bus(12'h197, 16'h8abc, 1'b1, 1'b0);
    bus(12'h191, 16'h0001, 1'b1, 1'b0);
    cyc(5);
    chk({o_l2_feedback_en, 3'h0, o_l2_integ}, 16'h8000);
    for (n = 0; n < 300 && o_lock_gpio[1] !== 1'b1; n++) @(posedge i_ref_clk);
    chk({14'h0, o_clk_good_gpio[1], o_lock_gpio[1]}, 16'h0003);
    chk({15'h0, o_lock_irq[1]}, 16'h0000);
    i_main_system_clock_on <= 1'b1;
    for (n = 0; n < 40 && o_lock_irq[1] !== 1'b1; n++) @(posedge i_ref_clk);
    chk({14'h0, o_clk_good_irq[1], o_lock_irq[1]}, 16'h0003);
    c2 = 12'h001;
    cyc(5);
    c2 = 12'h000;
    cyc(3);
    held = o_l2_integ;
    bus(12'h191, 16'h0003, 1'b1, 1'b0);
    rnd2 = 1'b1;
    cyc(8);
    chk({o_l2_feedback_en, 3'h0, o_l2_integ}, {4'h0, held});
    rnd2 = 1'b0;
    $display("loop two lock done");
    cyc(2);
    complete_run;
  end
endmodule
